// >>> hdl/ebpapc_top.sv
// Purpose: eight-pin general purpose port with per-pin pad controls
// Assumes: APB slave with zero wait states, pads resolved outside
// Notes: all pad controls are registered, one cycle after the cause
//
// Function
// - eight pins, one bit each per register, except the global current drive config
// - direction one turns the output driver off
// - direction zero drives the selected output source
// - port read shows pins, write hits latch
// - every port write is read-modify-write into latch
// - latch keeps the latest port or latch write
// - direction still controls driver in analog mode
// - analog pins read digitally as zero
// - open-drain sinks only, else push-pull
// - two-wire ownership forces open-drain
// - per-pin slew limit control
// - per-pin input threshold select
// - analog select leaves digital output alone
// - reset sets all analog select bits
// - per-pin weak pull-up enable
// - current drive needs pin and global enable
// - latch is default output source after reset
// - bit three reads one with master clear
// - analog output forces driver to high impedance
// - pull-up off while pin is an output
// - master clear forces pin three pull-up on
`timescale 1ns/1ps
`default_nettype none
module ebpapc_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pads
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe,
   output logic [7:0] pad_pullup,
   output logic [7:0] pad_slew_limit,
   output logic [7:0] pad_schmitt_sel,
   output logic [7:0] pad_analog_in,
   output logic [7:0] pad_ccd_source,
   output logic [7:0] pad_ccd_sink,
   output logic [1:0] pad_ccd_level,
   // system and peripheral side
   input wire logic master_clear_pin_enable,
   input wire logic [7:0] twowire_owns,
   input wire logic [7:0] periph_sel,
   input wire logic [7:0] periph_out,
   input wire logic [7:0] analog_out_en,
   output logic [7:0] digital_in
);

   // bit merge shared by both write paths
   function automatic logic [7:0] rmw_merge(
      input logic [7:0] old_v,
      input logic [7:0] new_v,
      input logic [7:0] mask
   );
      rmw_merge = (old_v & ~mask) | (new_v & mask);
   endfunction

   // control registers
   logic [7:0] lat_q, lat_d;
   logic [7:0] dir_q, dir_d;
   logic [7:0] ana_q, ana_d;
   logic [7:0] od_q, od_d;
   logic [7:0] slew_q, slew_d;
   logic [7:0] thr_q, thr_d;
   logic [7:0] pup_q, pup_d;
   logic [7:0] csrc_q, csrc_d;
   logic [7:0] csnk_q, csnk_d;
   logic ccd_en_q, ccd_en_d;
   logic [1:0] ccd_lvl_q, ccd_lvl_d;

   // bus outputs
   logic [31:0] prdata_q, prdata_d;
   logic pready_q;
   logic pslverr_q, pslverr_d;

   // pad outputs
   logic [7:0] pad_out_q, pad_out_d;
   logic [7:0] pad_oe_q, pad_oe_d;
   logic [7:0] pad_pullup_q, pad_pullup_d;
   logic [7:0] pad_slew_q;
   logic [7:0] pad_thr_q;
   logic [7:0] pad_ana_q;
   logic [7:0] pad_csrc_q, pad_csrc_d;
   logic [7:0] pad_csnk_q, pad_csnk_d;
   logic [1:0] pad_lvl_q;
   logic [7:0] digital_in_q, digital_in_d;

   // synchronised pins and read view
   logic [7:0] pin_sync;
   wire [7:0] pin_dig;
   wire [7:0] pin_rd;

   ebpapc_sync #(
      .W(ebpapc_pkg::PINS)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(pad_in),
      .q(pin_sync)
   );

   // analog inputs read as zero after the synchroniser
   assign pin_dig = pin_sync & ~ana_q;
   // bit three reads one when master clear owns the pin
   assign pin_rd = master_clear_pin_enable ?
      (pin_dig | ebpapc_pkg::MCLR_BIT_MASK) : pin_dig;

   // address decode
   wire setup_ph = psel & ~penable;
   wire access_ph = psel & penable & pready_q;
   wire wr_acc = access_ph & pwrite;
   wire sel_port = paddr == ebpapc_pkg::OFS_PORT;
   wire sel_lat = paddr == ebpapc_pkg::OFS_LAT;
   wire sel_dir = paddr == ebpapc_pkg::OFS_DIR;
   wire sel_ana = paddr == ebpapc_pkg::OFS_ANA;
   wire sel_od = paddr == ebpapc_pkg::OFS_OD;
   wire sel_slew = paddr == ebpapc_pkg::OFS_SLEW;
   wire sel_thr = paddr == ebpapc_pkg::OFS_THR;
   wire sel_pup = paddr == ebpapc_pkg::OFS_PUP;
   wire sel_csrc = paddr == ebpapc_pkg::OFS_CSRC;
   wire sel_csnk = paddr == ebpapc_pkg::OFS_CSNK;
   wire sel_ccfg = paddr == ebpapc_pkg::OFS_CCFG;
   wire hit = sel_port | sel_lat | sel_dir | sel_ana | sel_od | sel_slew |
      sel_thr | sel_pup | sel_csrc | sel_csnk | sel_ccfg;
   wire [7:0] wbyte = pwdata[7:0];

   // read data selection
   wire [7:0] ccfg_rd = {ccd_en_q, 5'h00, ccd_lvl_q};
   wire [7:0] rd_byte =
      sel_port ? pin_rd :
      sel_lat ? lat_q :
      sel_dir ? dir_q :
      sel_ana ? ana_q :
      sel_od ? od_q :
      sel_slew ? slew_q :
      sel_thr ? thr_q :
      sel_pup ? pup_q :
      sel_csrc ? csrc_q :
      sel_csnk ? csnk_q :
      sel_ccfg ? ccfg_rd : 8'h00;

   // answer is prepared in the setup cycle, held through access
   assign prdata_d = setup_ph ? ((hit && !pwrite) ? {24'h000000, rd_byte} :
      32'h00000000) : prdata_q;
   assign pslverr_d = setup_ph ? ~hit : pslverr_q;

   // latch writes: pins read, addressed bits replaced
   assign lat_d = (wr_acc && sel_port) ?
      rmw_merge(pin_rd, wbyte, ebpapc_pkg::PORT_WR_MASK) :
      (wr_acc && sel_lat) ?
      rmw_merge(pin_rd, wbyte, ebpapc_pkg::LAT_WR_MASK) :
      lat_q;
   assign dir_d = (wr_acc && sel_dir) ? wbyte : dir_q;
   assign ana_d = (wr_acc && sel_ana) ? wbyte : ana_q;
   assign od_d = (wr_acc && sel_od) ? wbyte : od_q;
   assign slew_d = (wr_acc && sel_slew) ? wbyte : slew_q;
   assign thr_d = (wr_acc && sel_thr) ? wbyte : thr_q;
   assign pup_d = (wr_acc && sel_pup) ? wbyte : pup_q;
   assign csrc_d = (wr_acc && sel_csrc) ? wbyte : csrc_q;
   assign csnk_d = (wr_acc && sel_csnk) ? wbyte : csnk_q;
   assign ccd_en_d = (wr_acc && sel_ccfg) ?
      wbyte[ebpapc_pkg::CCD_EN_BIT] : ccd_en_q;
   assign ccd_lvl_d = (wr_acc && sel_ccfg) ?
      wbyte[ebpapc_pkg::CCD_LVL_LSB +: 2] : ccd_lvl_q;

   // output source: latch unless a peripheral is routed in
   wire [7:0] out_src = (periph_sel & periph_out) | (~periph_sel & lat_q);
   // open-drain from own bit or two-wire ownership
   wire [7:0] od_eff = od_q | twowire_owns;
   // analog select is deliberately not part of the enable
   wire [7:0] drv_en = ~dir_q & ~analog_out_en;
   // per pin: open-drain pins drive only their low level
   assign pad_oe_d = drv_en & ((od_eff & ~out_src) | ~od_eff);
   assign pad_out_d = out_src & ~od_eff;

   // pull-up off for outputs, forced on for master clear pin
   wire [7:0] mclr_pup = master_clear_pin_enable ?
      ebpapc_pkg::MCLR_BIT_MASK : 8'h00;
   assign pad_pullup_d = (pup_q & dir_q) | mclr_pup;

   // current drive gated by the global enable
   assign pad_csrc_d = csrc_q & {8{ccd_en_q}};
   assign pad_csnk_d = csnk_q & {8{ccd_en_q}};
   assign digital_in_d = pin_dig;

   // control register file
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_q <= ebpapc_pkg::RST_LAT;
         dir_q <= ebpapc_pkg::RST_DIR;
         ana_q <= ebpapc_pkg::RST_ANA;
         od_q <= ebpapc_pkg::RST_OD;
         slew_q <= ebpapc_pkg::RST_SLEW;
         thr_q <= ebpapc_pkg::RST_THR;
         pup_q <= ebpapc_pkg::RST_PUP;
         csrc_q <= ebpapc_pkg::RST_CSRC;
         csnk_q <= ebpapc_pkg::RST_CSNK;
         ccd_en_q <= ebpapc_pkg::RST_CCD_EN;
         ccd_lvl_q <= ebpapc_pkg::RST_CCD_LVL;
      end else begin
         lat_q <= lat_d;
         dir_q <= dir_d;
         ana_q <= ana_d;
         od_q <= od_d;
         slew_q <= slew_d;
         thr_q <= thr_d;
         pup_q <= pup_d;
         csrc_q <= csrc_d;
         csnk_q <= csnk_d;
         ccd_en_q <= ccd_en_d;
         ccd_lvl_q <= ccd_lvl_d;
      end
   end

   // bus answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= 1'b1;
         pslverr_q <= pslverr_d;
      end
   end

   // pad control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out_q <= 8'h00;
         pad_oe_q <= 8'h00;
         pad_pullup_q <= 8'h00;
         pad_slew_q <= ebpapc_pkg::RST_SLEW;
         pad_thr_q <= ebpapc_pkg::RST_THR;
         pad_ana_q <= ebpapc_pkg::RST_ANA;
         pad_csrc_q <= 8'h00;
         pad_csnk_q <= 8'h00;
         pad_lvl_q <= ebpapc_pkg::RST_CCD_LVL;
         digital_in_q <= 8'h00;
      end else begin
         pad_out_q <= pad_out_d;
         pad_oe_q <= pad_oe_d;
         pad_pullup_q <= pad_pullup_d;
         pad_slew_q <= slew_q;
         pad_thr_q <= thr_q;
         pad_ana_q <= ana_q;
         pad_csrc_q <= pad_csrc_d;
         pad_csnk_q <= pad_csnk_d;
         pad_lvl_q <= ccd_lvl_q;
         digital_in_q <= digital_in_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pad_out = pad_out_q;
   assign pad_oe = pad_oe_q;
   assign pad_pullup = pad_pullup_q;
   assign pad_slew_limit = pad_slew_q;
   assign pad_schmitt_sel = pad_thr_q;
   assign pad_analog_in = pad_ana_q;
   assign pad_ccd_source = pad_csrc_q;
   assign pad_ccd_sink = pad_csnk_q;
   assign pad_ccd_level = pad_lvl_q;
   assign digital_in = digital_in_q;

   // checks
   wire [7:0] pp_mask = ~dir_q & ~analog_out_en & ~od_eff;

   a_input_no_drive: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 (pad_oe_q & $past(dir_q)) == 8'h00)
      else $error("input pin has its driver enabled");

   a_pushpull_drive: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 ((pad_oe_q & $past(pp_mask)) == $past(pp_mask)) &&
      ((pad_out_q & $past(pp_mask)) == ($past(out_src) & $past(pp_mask))))
      else $error("push-pull output not driving its source");

   a_port_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && sel_port) |=>
      (prdata_q == {24'h000000, $past(pin_rd)}))
      else $error("pin value read does not show pins");

   a_rmw_latch: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && sel_port) |=> lat_q ==
      (($past(pin_rd) & ~ebpapc_pkg::PORT_WR_MASK) |
      ($past(wbyte) & ebpapc_pkg::PORT_WR_MASK)))
      else $error("port write did not merge into latch");

   a_analog_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 (digital_in_q & $past(ana_q)) == 8'h00)
      else $error("analog pin reads nonzero digitally");

   a_open_drain_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 (pad_out_q & $past(od_eff)) == 8'h00)
      else $error("open-drain pin driven high");

   a_reset_analog: assert property (
      @(posedge pclk)
      $rose(presetn) |-> (ana_q == ebpapc_pkg::RST_ANA))
      else $error("analog select not set after reset");

   a_pullup_gating: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 (pad_pullup_q & ~$past(dir_q) & ~$past(mclr_pup)) == 8'h00)
      else $error("pull-up active on an output pin");

   a_mclr_pullup: assert property (
      @(posedge pclk) disable iff (!presetn)
      master_clear_pin_enable |=> pad_pullup_q[ebpapc_pkg::PIN_MCLR])
      else $error("master clear pin lost its pull-up");

   a_ccd_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ccd_en_q |=> (pad_ccd_source == 8'h00) && (pad_ccd_sink == 8'h00))
      else $error("current drive active without global enable");

   a_aout_hiz: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 (pad_oe_q & $past(analog_out_en)) == 8'h00)
      else $error("analog output pin still driven");

   a_mclr_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_ph && !pwrite && sel_port && master_clear_pin_enable) |=>
      prdata_q[ebpapc_pkg::PIN_MCLR])
      else $error("bit three not one under master clear");

   a_unmapped_err: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_ph && !hit) |=> pslverr_q && (prdata_q == 32'h00000000))
      else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// >>> hdl/ebpapc_pkg.sv
// Purpose: shared constants of the eight-pin port control block
// Assumes: APB slave, one 32-bit aligned word per register
// Notes: all offsets are byte addresses on paddr
package ebpapc_pkg;
   localparam int unsigned PINS = 8;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned SYNC_STAGES = 2;
   // register byte offsets
   localparam logic [11:0] OFS_PORT = 12'h000;
   localparam logic [11:0] OFS_LAT = 12'h004;
   localparam logic [11:0] OFS_DIR = 12'h008;
   localparam logic [11:0] OFS_ANA = 12'h00c;
   localparam logic [11:0] OFS_OD = 12'h010;
   localparam logic [11:0] OFS_SLEW = 12'h014;
   localparam logic [11:0] OFS_THR = 12'h018;
   localparam logic [11:0] OFS_PUP = 12'h01c;
   localparam logic [11:0] OFS_CSRC = 12'h020;
   localparam logic [11:0] OFS_CSNK = 12'h024;
   localparam logic [11:0] OFS_CCFG = 12'h028;
   // reset values
   localparam logic [7:0] RST_DIR = 8'hff;
   localparam logic [7:0] RST_LAT = 8'hc8;
   localparam logic [7:0] RST_ANA = 8'hff;
   localparam logic [7:0] RST_OD = 8'h00;
   localparam logic [7:0] RST_SLEW = 8'hff;
   localparam logic [7:0] RST_THR = 8'hff;
   localparam logic [7:0] RST_PUP = 8'h00;
   localparam logic [7:0] RST_CSRC = 8'h00;
   localparam logic [7:0] RST_CSNK = 8'h00;
   localparam logic RST_CCD_EN = 1'b0;
   localparam logic [1:0] RST_CCD_LVL = 2'h0;
   // field positions
   localparam int unsigned CCD_EN_BIT = 7;
   localparam int unsigned CCD_LVL_LSB = 0;
   localparam int unsigned PIN_MCLR = 3;
   // writable bits of the pin value register; bit 3 is read-only
   localparam logic [7:0] PORT_WR_MASK = 8'hf7;
   localparam logic [7:0] LAT_WR_MASK = 8'hff;
   localparam logic [7:0] MCLR_BIT_MASK = 8'h08;
endpackage

// >>> hdl/ebpapc_sync.sv
// Purpose: multi-flop level synchroniser for the pad inputs
// Assumes: inputs are levels, one clock domain on the far side
// Notes: only the last stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module ebpapc_sync #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule
`default_nettype wire

// >>> sim/ebpapc_pins.sv
// Purpose: pin side model, resolves each pad from all its drivers
// Assumes: one external driver per pin, enabled by ext_en
// Notes: a pin that nobody drives toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module ebpapc_pins (
   // clock
   input wire logic pclk,
   // pad controls from the port
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pad_pullup,
   // external circuit
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   // resolved levels
   output logic [7:0] pad_in
);
   logic [7:0] float_q = 8'h00;
   always_ff @(posedge pclk) begin
      float_q <= ~pad_in;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe[i])
            pad_in[i] = pad_out[i];
         else if (ext_en[i])
            pad_in[i] = ext_val[i];
         else if (pad_pullup[i])
            pad_in[i] = 1'b1;
         else
            pad_in[i] = float_q[i];
      end
   end
endmodule
`default_nettype wire

// >>> sim/eight_bit_port_a_pin_control_tb_top.sv
// Purpose: self-checking bench of the eight-pin port
// Assumes: zero wait APB slave, pins resolved by the pin model
// Notes: pad checks wait four edges so synchronised reads have landed
`timescale 1ns/1ps
`default_nettype none
module eight_bit_port_a_pin_control_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, master_clear_pin_enable = 1'b0;
   logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, pad_slew_limit;
   logic [7:0] pad_schmitt_sel, pad_analog_in, pad_ccd_source;
   logic [7:0] pad_ccd_sink, digital_in;
   logic [1:0] pad_ccd_level;
   logic [7:0] twowire_owns = 8'h00;
   logic [7:0] periph_sel = 8'h00;
   logic [7:0] periph_out = 8'h00;
   logic [7:0] analog_out_en = 8'h00;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] ext_en = 8'h00;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #2 pclk = ~pclk;
   ebpapc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe,
      .pad_pullup, .pad_slew_limit, .pad_schmitt_sel, .pad_analog_in,
      .pad_ccd_source, .pad_ccd_sink, .pad_ccd_level,
      .master_clear_pin_enable, .twowire_owns, .periph_sel, .periph_out,
      .analog_out_en, .digital_in);
   ebpapc_pins pins (.pclk, .pad_out, .pad_oe, .pad_pullup, .ext_val,
      .ext_en, .pad_in);
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [7:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      chk(r, {24'h000000, x});
   endtask
   task automatic settle;
      repeat (4) @(posedge pclk);
   endtask
   task automatic t_reset_vals;
      rd(ebpapc_pkg::OFS_LAT, 8'hc8);
      rd(ebpapc_pkg::OFS_DIR, 8'hff);
      rd(ebpapc_pkg::OFS_ANA, 8'hff);
      rd(ebpapc_pkg::OFS_OD, 8'h00);
      rd(ebpapc_pkg::OFS_SLEW, 8'hff);
      rd(ebpapc_pkg::OFS_THR, 8'hff);
      rd(ebpapc_pkg::OFS_PUP, 8'h00);
      rd(ebpapc_pkg::OFS_CSRC, 8'h00);
      rd(ebpapc_pkg::OFS_CSNK, 8'h00);
      rd(ebpapc_pkg::OFS_CCFG, 8'h00);
      rd(ebpapc_pkg::OFS_PORT, 8'h00);
      chk(pad_analog_in, 8'hff);
      chk(pad_oe, 8'h00);
   endtask
   task automatic t_output;
      wr(ebpapc_pkg::OFS_ANA, 8'h00);
      wr(ebpapc_pkg::OFS_LAT, 8'h5a);
      wr(ebpapc_pkg::OFS_DIR, 8'h00);
      settle();
      chk(pad_oe, 8'hff);
      chk(pad_out, 8'h5a);
      rd(ebpapc_pkg::OFS_PORT, 8'h5a);
      // bit three keeps the pin level, here high
      wr(ebpapc_pkg::OFS_PORT, 8'ha5);
      rd(ebpapc_pkg::OFS_LAT, 8'had);
      wr(ebpapc_pkg::OFS_PORT, 8'h11);
      wr(ebpapc_pkg::OFS_LAT, 8'h66);
      rd(ebpapc_pkg::OFS_LAT, 8'h66);
      wr(ebpapc_pkg::OFS_ANA, 8'h0f);
      settle();
      chk(pad_oe, 8'hff);
      chk(pad_out, 8'h66);
      rd(ebpapc_pkg::OFS_PORT, 8'h60);
      chk(digital_in, 8'h60);
   endtask
   task automatic t_input;
      wr(ebpapc_pkg::OFS_ANA, 8'h00);
      wr(ebpapc_pkg::OFS_DIR, 8'hff);
      ext_val <= 8'hc3;
      ext_en <= 8'hff;
      settle();
      chk(pad_oe, 8'h00);
      rd(ebpapc_pkg::OFS_PORT, 8'hc3);
      master_clear_pin_enable <= 1'b1;
      wr(ebpapc_pkg::OFS_PUP, 8'h00);
      settle();
      rd(ebpapc_pkg::OFS_PORT, 8'hcb);
      chk(pad_pullup, 8'h08);
      wr(ebpapc_pkg::OFS_DIR, 8'h0f);
      wr(ebpapc_pkg::OFS_PUP, 8'hf7);
      settle();
      chk(pad_pullup, 8'h0f);
      rd(ebpapc_pkg::OFS_PUP, 8'hf7);
      master_clear_pin_enable <= 1'b0;
      settle();
      chk(pad_pullup, 8'h07);
   endtask
   task automatic t_drive;
      ext_en <= 8'h00;
      wr(ebpapc_pkg::OFS_DIR, 8'h00);
      wr(ebpapc_pkg::OFS_LAT, 8'h0f);
      wr(ebpapc_pkg::OFS_OD, 8'hf0);
      twowire_owns <= 8'h03;
      settle();
      chk(pad_out, 8'h0c);
      chk(pad_oe, 8'hfc);
      twowire_owns <= 8'h00;
      wr(ebpapc_pkg::OFS_OD, 8'h00);
      periph_sel <= 8'h01;
      analog_out_en <= 8'h80;
      settle();
      chk(pad_out, 8'h0e);
      chk(pad_oe, 8'h7f);
   endtask
   task automatic t_misc;
      logic [31:0] r;
      logic e;
      wr(ebpapc_pkg::OFS_SLEW, 8'h5a);
      periph_sel <= 8'h00;
      wr(ebpapc_pkg::OFS_THR, 8'h33);
      wr(ebpapc_pkg::OFS_CCFG, 8'hff);
      wr(ebpapc_pkg::OFS_CSRC, 8'h0f);
      wr(ebpapc_pkg::OFS_CSNK, 8'hf0);
      settle();
      chk(pad_slew_limit, 8'h5a);
      chk(pad_schmitt_sel, 8'h33);
      chk(pad_ccd_source, 8'h0f);
      chk(pad_ccd_sink, 8'hf0);
      chk(pad_ccd_level, 2'h3);
      rd(ebpapc_pkg::OFS_CCFG, 8'h83);
      wr(ebpapc_pkg::OFS_CSRC, 8'h00);
      settle();
      chk(pad_ccd_source, 8'h00);
      apb(1'b0, 12'h100, 8'h00, r, e);
      chk(e, 1'b1);
      chk(r, 32'h00000000);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset_vals();
      t_output();
      t_input();
      t_drive();
      t_misc();
      end_of_test();
   end
endmodule
`default_nettype wire
